// >>> rtl/vrc_top.sv
`timescale 1ns/1ps
`default_nettype none

module vrc_top #(
  parameter int SETTLE_CYCLES = vrc_pkg::VRC_SETTLE_CYCLES
) (
  input  wire logic                               hclk,
  input  wire logic                               hresetn,
  input  wire logic                               hsel,
  input  wire logic [31:0]                        haddr,
  input  wire logic [1:0]                         htrans,
  input  wire logic                               hwrite,
  input  wire logic [2:0]                         hsize,
  input  wire logic [31:0]                        hwdata,
  input  wire logic                               hready,
  output var  logic [31:0]                        hrdata,
  output var  logic                               hreadyout,
  output var  logic                               hresp,
  input  wire logic                               ref_pin_in,
  input  wire logic                               pin_digital_out,
  input  wire logic                               pin_digital_oe_n,
  output var  logic                               ref_pin_out,
  output var  logic                               ref_pin_oe_n,
  output var  logic                               ref_pin_digital_read,
  output var  logic                               ref_pin_analog_connect,
  output var  logic                               dac_current_enable,
  output var  logic [vrc_pkg::VRC_LEVEL_BITS-1:0] dac_level_out,
  output var  logic                               dac_out_force_pos,
  output var  logic                               dac_out_force_neg,
  output var  logic [1:0]                         dac_pos_source_sel,
  output var  logic                               dac_neg_source_sel,
  output var  logic                               fixed_ref_on,
  output var  logic [1:0]                         fixed_ref_gain_sel,
  output var  logic                               sleep_active
);
  import vrc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [7:0]  fr_ctrl;
    logic [7:0]  dv_ctrl;
    logic [7:0]  lv_sel;
    logic        sleep;
    logic        dph_write;
    logic        dph_valid;
    logic [11:0] dph_addr;
    logic [31:0] rdata;
    logic        pin_out;
    logic        pin_oe_n;
    logic        pin_read;
    logic        pin_analog;
    logic        dac_en;
    logic [4:0]  level;
    logic        force_pos;
    logic        force_neg;
    logic [1:0]  pos_sel;
    logic        neg_sel;
    logic        fr_on;
    logic [1:0]  gain;
    logic        ready;
    logic        resp;
  } vrc_state_type;

  vrc_state_type state_q;
  vrc_state_type state_d;

  logic settled;
  logic pin_level;

  vrc_settle_timer #(
    .SETTLE_CYCLES (SETTLE_CYCLES)
  ) u_settle (
    .hclk    (hclk),
    .hresetn (hresetn),
    .enable  (state_q.fr_ctrl[VRC_FR_ENABLE_BIT]),
    .settled (settled)
  );

  vrc_pin_sync u_pin_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .pin_in  (ref_pin_in),
    .level   (pin_level)
  );

  ////////////////////////////////////////////////////////////////////////////////
  logic        addr_phase;
  logic [11:0] req_addr;
  logic [7:0]  wbyte;
  logic [31:0] read_mux;

  assign addr_phase = hsel && hready && htrans[1];
  assign req_addr   = {haddr[11:2], 2'b00};
  assign wbyte      = hwdata[7:0];

  // Read view, decoded from the address phase itself; the settled flag is live hardware state.
  // A write still in its data phase is not yet stored, so a read right behind it sees the old value.
  always_comb begin
    read_mux = 32'h0;
    if (req_addr == VRC_FIXED_REF_CONTROL_ADDR) begin
      read_mux[7:0] = state_q.fr_ctrl & VRC_FR_WMASK;
      read_mux[VRC_FR_SETTLED_BIT] = settled;
    end else if (req_addr == VRC_DIVIDER_REF_CONTROL_ADDR) begin
      read_mux[7:0] = state_q.dv_ctrl & VRC_DV_WMASK;
    end else if (req_addr == VRC_DIVIDER_LEVEL_SELECT_ADDR) begin
      read_mux[7:0] = state_q.lv_sel & VRC_LV_WMASK;
    end else if (req_addr == VRC_SLEEP_CONTROL_ADDR) begin
      read_mux[0] = state_q.sleep;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    state_d = state_q;

    // Zero-wait slave: the data phase always completes in one cycle.
    if (addr_phase) begin
      state_d.dph_valid = 1'b1;
      state_d.dph_write = hwrite;
      state_d.dph_addr  = {haddr[11:2], 2'b00};
    end else begin
      state_d.dph_valid = 1'b0;
      state_d.dph_write = 1'b0;
    end

    if (addr_phase && !hwrite) begin
      state_d.dph_addr = {haddr[11:2], 2'b00};
    end

    // Writes land in the data phase. Only writable bits are stored.
    if (state_q.dph_valid && state_q.dph_write) begin
      if (state_q.dph_addr == VRC_FIXED_REF_CONTROL_ADDR) begin
        state_d.fr_ctrl = wbyte & VRC_FR_WMASK;
      end else if (state_q.dph_addr == VRC_DIVIDER_REF_CONTROL_ADDR) begin
        state_d.dv_ctrl = wbyte & VRC_DV_WMASK;
      end else if (state_q.dph_addr == VRC_DIVIDER_LEVEL_SELECT_ADDR) begin
        state_d.lv_sel = wbyte & VRC_LV_WMASK;
      end else if (state_q.dph_addr == VRC_SLEEP_CONTROL_ADDR) begin
        // Sleep entry and wake touch no control register contents.
        state_d.sleep = wbyte[0];
      end
    end

    // Read data is loaded at the address phase edge: with no wait states the master takes it
    // at the very next edge, so a register loaded one edge later would answer too late.
    if (addr_phase && !hwrite) begin
      state_d.rdata = read_mux;
    end else begin
      state_d.rdata = 32'h0;
    end

    // Analogue controls come only from these registers, never from comparators.
    state_d.dac_en    = state_d.dv_ctrl[VRC_DV_ENABLE_BIT];
    state_d.level     = state_d.lv_sel[VRC_LEVEL_BITS-1:0];
    state_d.pos_sel   = state_d.dv_ctrl[VRC_DV_POS_LSB +: 2];
    state_d.neg_sel   = state_d.dv_ctrl[VRC_DV_NEG_BIT];
    state_d.force_pos = !state_d.dv_ctrl[VRC_DV_ENABLE_BIT] && state_d.dv_ctrl[VRC_DV_LOWPWR_BIT];
    state_d.force_neg = !state_d.dv_ctrl[VRC_DV_ENABLE_BIT] && !state_d.dv_ctrl[VRC_DV_LOWPWR_BIT];
    state_d.fr_on     = state_d.fr_ctrl[VRC_FR_ENABLE_BIT];
    state_d.gain      = state_d.fr_ctrl[VRC_FR_GAIN_LSB +: 2];

    // With the pin taken for the reference, the digital path is cut.
    if (state_d.dv_ctrl[VRC_DV_PINOE_BIT]) begin
      state_d.pin_analog = 1'b1;
      state_d.pin_oe_n   = 1'b1;
      state_d.pin_out    = 1'b0;
      state_d.pin_read   = 1'b0;
    end else begin
      state_d.pin_analog = 1'b0;
      state_d.pin_oe_n   = pin_digital_oe_n;
      state_d.pin_out    = pin_digital_out;
      state_d.pin_read   = pin_level;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q          <= '0;
      state_q.fr_ctrl  <= {2'b00, VRC_GAIN_RESET, 4'h0};
      state_q.gain     <= VRC_GAIN_RESET;
      state_q.lv_sel   <= {3'b000, VRC_LEVEL_RESET};
      state_q.pin_oe_n <= 1'b1;
      state_q.force_neg <= 1'b1;
      state_q.ready    <= 1'b1;
    end else begin
      state_q <= state_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  assign hrdata                 = state_q.rdata;
  assign hreadyout              = state_q.ready;
  assign hresp                  = state_q.resp;
  assign ref_pin_out            = state_q.pin_out;
  assign ref_pin_oe_n           = state_q.pin_oe_n;
  assign ref_pin_digital_read   = state_q.pin_read;
  assign ref_pin_analog_connect = state_q.pin_analog;
  assign dac_current_enable     = state_q.dac_en;
  assign dac_level_out          = state_q.level;
  assign dac_out_force_pos      = state_q.force_pos;
  assign dac_out_force_neg      = state_q.force_neg;
  assign dac_pos_source_sel     = state_q.pos_sel;
  assign dac_neg_source_sel     = state_q.neg_sel;
  assign fixed_ref_on           = state_q.fr_on;
  assign fixed_ref_gain_sel     = state_q.gain;
  assign sleep_active           = state_q.sleep;

endmodule : vrc_top

`default_nettype wire

// >>> rtl/vrc_pkg.sv
package vrc_pkg;

  // Register byte addresses on the bus.
  localparam logic [11:0] VRC_FIXED_REF_CONTROL_ADDR    = 12'h000;
  localparam logic [11:0] VRC_DIVIDER_REF_CONTROL_ADDR  = 12'h004;
  localparam logic [11:0] VRC_DIVIDER_LEVEL_SELECT_ADDR = 12'h008;
  localparam logic [11:0] VRC_SLEEP_CONTROL_ADDR        = 12'h00c;

  // Field positions of the fixed reference control register.
  localparam int VRC_FR_ENABLE_BIT  = 7;
  localparam int VRC_FR_SETTLED_BIT = 6;
  localparam int VRC_FR_GAIN_LSB    = 4;

  // Field positions of the divider control register.
  localparam int VRC_DV_ENABLE_BIT  = 7;
  localparam int VRC_DV_LOWPWR_BIT  = 6;
  localparam int VRC_DV_PINOE_BIT   = 5;
  localparam int VRC_DV_POS_LSB     = 2;
  localparam int VRC_DV_NEG_BIT     = 0;

  // Writable masks; all other bits read zero, apart from the settled flag in bit 6 of the fixed reference control and bit 0 of the sleep control.
  localparam logic [7:0] VRC_FR_WMASK = 8'hb0;
  localparam logic [7:0] VRC_DV_WMASK = 8'hed;
  localparam logic [7:0] VRC_LV_WMASK = 8'h1f;

  // Reset values.
  localparam logic [1:0] VRC_GAIN_RESET   = 2'h1;
  localparam logic [4:0] VRC_LEVEL_RESET  = 5'h00;

  // Level code width.
  localparam int VRC_LEVEL_BITS = 5;

  // Settling time of the fixed reference and its cycle count at 200 MHz.
  localparam int VRC_CLK_MHZ       = 200;
  localparam int VRC_SETTLE_US     = 25;
  localparam int VRC_SETTLE_CYCLES = VRC_SETTLE_US * VRC_CLK_MHZ;

  typedef enum logic [1:0] {
    VRC_POS_SUPPLY,
    VRC_POS_EXT_REF,
    VRC_POS_FIXED_REF,
    VRC_POS_RESERVED
  } vrc_pos_src_type;

endpackage : vrc_pkg

// >>> rtl/vrc_settle_timer.sv
`timescale 1ns/1ps
`default_nettype none

module vrc_settle_timer #(
  parameter int SETTLE_CYCLES = 5000
) (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic enable,
  output var  logic settled
);

  typedef struct packed {
    logic [31:0] count;
    logic        settled;
  } vrc_timer_state_type;

  vrc_timer_state_type state_q;
  vrc_timer_state_type state_d;

  // The flag drops at the first edge after the enable goes away, so a restart always waits the full count.
  always_comb begin
    state_d = state_q;
    if (!enable) begin
      state_d.count   = 32'h0;
      state_d.settled = 1'b0;
    end else if (!state_q.settled) begin
      if (state_q.count >= 32'(SETTLE_CYCLES - 1)) begin
        state_d.settled = 1'b1;
      end else begin
        state_d.count = state_q.count + 32'h1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign settled = state_q.settled;

endmodule : vrc_settle_timer

`default_nettype wire

// >>> rtl/vrc_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none

module vrc_pin_sync (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic pin_in,
  output var  logic level
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
  } vrc_sync_state_type;

  vrc_sync_state_type state_q;
  vrc_sync_state_type state_d;

  // A change is accepted only once the second and third stages agree.
  always_comb begin
    state_d    = state_q;
    state_d.s1 = pin_in;
    state_d.s2 = state_q.s1;
    state_d.s3 = state_q.s2;
    if (state_q.s2 == state_q.s3) begin
      state_d.level = state_q.s3;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign level = state_q.level;

endmodule : vrc_pin_sync

`default_nettype wire

// >>> tb/vrc_checker.sv
`timescale 1ns/1ps
`default_nettype none

module vrc_checker (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        ref_pin_out,
  input wire logic        ref_pin_oe_n,
  input wire logic        ref_pin_digital_read,
  input wire logic        ref_pin_analog_connect,
  input wire logic        dac_current_enable,
  input wire logic [4:0]  dac_level_out,
  input wire logic        dac_out_force_pos,
  input wire logic        dac_out_force_neg,
  input wire logic [1:0]  dac_pos_source_sel,
  input wire logic        dac_neg_source_sel,
  input wire logic        fixed_ref_on
);
  logic wr_a_q;
  logic wr_b_q;
  logic wr_c_q;
  logic wr_recent;

  // A control output may move only one or two edges after a write address phase.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {wr_a_q, wr_b_q, wr_c_q} <= 3'h0;
    end else begin
      {wr_a_q, wr_b_q, wr_c_q} <= {hsel && hready && htrans[1] && hwrite, wr_a_q, wr_b_q};
    end
  end
  assign wr_recent = wr_b_q || wr_c_q;

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_dac_on_noforce: assert property (dac_current_enable |-> !dac_out_force_pos && !dac_out_force_neg)
    else $error("low-power force active while divider enabled");
  a_lowpwr_state: assert property (!dac_current_enable |-> dac_out_force_pos != dac_out_force_neg)
    else $error("low-power output state not exactly one source");
  a_pin_read_zero: assert property (ref_pin_analog_connect |-> !ref_pin_digital_read)
    else $error("pin read not zero while reference routed");
  a_pin_override: assert property (ref_pin_analog_connect |-> ref_pin_oe_n && !ref_pin_out)
    else $error("digital driver not off while reference routed");
  a_rdata_upper: assert property (hrdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  a_ctl_written: assert property ($changed({dac_current_enable, dac_pos_source_sel, dac_neg_source_sel,
                                            ref_pin_analog_connect}) |-> wr_recent)
    else $error("divider control moved without a write");
  a_level_written: assert property ($changed(dac_level_out) |-> wr_recent)
    else $error("level code moved without a write");
  a_fixed_written: assert property ($changed(fixed_ref_on) |-> wr_recent)
    else $error("fixed reference enable moved without a write");
endmodule : vrc_checker

bind vrc_top vrc_checker u_chk (.hclk, .hresetn, .hsel, .htrans, .hwrite, .hready, .hrdata, .ref_pin_out,
  .ref_pin_oe_n, .ref_pin_digital_read, .ref_pin_analog_connect, .dac_current_enable, .dac_level_out,
  .dac_out_force_pos, .dac_out_force_neg, .dac_pos_source_sel, .dac_neg_source_sel, .fixed_ref_on);

`default_nettype wire

// >>> tb/voltage_reference_control_tb.sv
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin err_total++; \
  $display("wrong value %s expected %0h seen %0h", nm, e, g); end end

module voltage_reference_control_tb;
  import vrc_pkg::*;
  localparam int S = 8;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, lf = 32'h8779ec13, r;
  logic [1:0]  htrans = 2'h0, psel, gsel;
  logic [2:0]  hsize = 3'h2;
  logic        pin_in = 1'b0, pdo = 1'b0, pdoe_n = 1'b1, pout, poe_n, prd, pcon, cen, fpos, fneg, nsel, fon, slp;
  logic [4:0]  lvl;
  logic [7:0]  m [5];
  logic [7:0]  wm [5] = '{VRC_FR_WMASK, VRC_DV_WMASK, VRC_LV_WMASK, 8'h01, 8'h00};
  int          err_total = 0, n_compared = 0;
  wire logic   hready = hreadyout;

  always #2.5 hclk = ~hclk;

  vrc_top #(.SETTLE_CYCLES(S)) dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hrdata, .hreadyout, .hresp, .ref_pin_in(pin_in), .pin_digital_out(pdo),
    .pin_digital_oe_n(pdoe_n), .ref_pin_out(pout), .ref_pin_oe_n(poe_n), .ref_pin_digital_read(prd),
    .ref_pin_analog_connect(pcon), .dac_current_enable(cen), .dac_level_out(lvl),
    .dac_out_force_pos(fpos), .dac_out_force_neg(fneg), .dac_pos_source_sel(psel),
    .dac_neg_source_sel(nsel), .fixed_ref_on(fon), .fixed_ref_gain_sel(gsel), .sleep_active(slp));

  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nxt

  task automatic xfer(input logic w, input int i, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= 32'(i * 4);
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    r = hrdata;
  endtask : xfer

  task automatic wr(input int i, input logic [31:0] d);
    xfer(1'b1, i, d);
    m[i] = d[7:0] & wm[i];
    repeat (2) @(posedge hclk);
    #1;
  endtask : wr

  task automatic rd(input int i, input logic [7:0] ign, input logic [7:0] ex);
    xfer(1'b0, i, 32'h0);
    `CHK("read data", {24'h0, ex & ~ign}, r & ~{24'h0, ign})
    `CHK("response", 1'b0, hresp)
  endtask : rd

  task automatic chk_out;
    `CHK("divider current", m[1][7], cen)
    `CHK("level code", m[2][4:0], lvl)
    `CHK("force pos", !m[1][7] && m[1][6], fpos)
    `CHK("force neg", !m[1][7] && !m[1][6], fneg)
    `CHK("pin connect", m[1][5], pcon)
    `CHK("pos select", m[1][3:2], psel)
    `CHK("neg select", m[1][0], nsel)
    `CHK("fixed on", m[0][7], fon)
    `CHK("gain", m[0][5:4], gsel)
  endtask : chk_out

  task automatic do_reset;
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    m = '{8'h10, 8'h00, 8'h00, 8'h00, 8'h00};
    @(posedge hclk);
    #1;
    chk_out();
    for (int i = 0; i < 5; i++) rd(i, 8'h00, m[i]);
    $display("test reset done");
  endtask : do_reset

  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : complete_run

  initial begin
    repeat (20000) @(posedge hclk);
    err_total++;
    complete_run();
  end

  initial begin
    do_reset();
    for (int i = 0; i < 20; i++) begin
      lf = nxt(lf);
      wr(i % 5, {lf[31:6], 2'(i % 3 + 1), 2'((i >> 2) % 3), lf[1:0]});
      chk_out();
      rd(i % 5, (i % 5 == 0) ? 8'h40 : 8'h00, m[i % 5]);
    end
    $display("test random registers done");
    wr(0, 32'h10);
    wr(0, 32'h90);
    rd(0, 8'h00, m[0]);
    repeat (2 * S) @(posedge hclk);
    rd(0, 8'h00, m[0] | 8'h40);
    wr(0, 32'h50);
    rd(0, 8'h00, m[0]);
    $display("test settle done");
    wr(1, 32'h49);
    wr(3, 32'h1);
    `CHK("sleep", 1'b1, slp)
    rd(1, 8'h00, 8'h49 & VRC_DV_WMASK);
    wr(3, 32'h0);
    chk_out();
    $display("test sleep done");
    for (int k = 0; k < 4; k++) begin
      lf = nxt(lf);
      wr(1, {26'h0, k[0], 5'h0});
      @(posedge hclk);
      pdo <= lf[0];
      pdoe_n <= lf[1];
      pin_in <= lf[2];
      repeat (8) @(posedge hclk);
      #1;
      `CHK("pin out", m[1][5] ? 1'b0 : lf[0], pout)
      `CHK("pin oe_n", m[1][5] ? 1'b1 : lf[1], poe_n)
      `CHK("pin read", m[1][5] ? 1'b0 : lf[2], prd)
    end
    $display("test pin done");
    do_reset();
    complete_run();
  end
endmodule : voltage_reference_control_tb

`default_nettype wire
